// ---- src/wk_byte_select.sv ----
`timescale 1ns/1ps
module wk_byte_select
  import wk_pkg::*;
#(
  parameter int unsigned IN_BYTES  = 160,
  parameter int unsigned OUT_BYTES = 64
)(
  input  wire logic [IN_BYTES*8-1:0]  win,
  input  wire logic [7:0]             ofs,
  output logic      [OUT_BYTES*8-1:0] sel
);
  logic [IN_BYTES*8-1:0] shifted;

  // Leading bytes shift out the top; zeros fill past the window end
  always_comb
  begin
    shifted = win << {ofs, 3'b000};
    sel     = shifted[IN_BYTES*8-1 -: OUT_BYTES*8];
  end
endmodule

// ---- src/wk_key_builder.sv ----
// Functional notes
// - LLC frames: source field is control byte then payload bytes 0..14.
// - SNAP frames: source field is PID bytes 2..0 then payload bytes 0..12.
// - IPv4 frames: IPv4 source address in source field bits 31..0.
// - IPv6 frames: full IPv6 source address in source field.
// - Other EtherType frames: source field is payload bytes 0..15.
// - Transport flag set for IP protocol or next header 6 or 17.
// - Transport flag also forced to one for OAM Y.1731 frames.
// - Stream flag set only for IPv4 or IPv6 with protocol 6.
// - Source-port field holds L4 source port, or level code for OAM.
// - Maintenance level is thermometer coded, ones filled from bit zero.
// - Eight-bit range mask from typed range checkers.
// - Range checkers use frame values, but remapped DSCP.
// - Raw payload field is 64 bytes from the current frame pointer.
// - EtherType flag set when type-or-length is at least 0x600.
// - Length-encoded frames: IP-or-SNAP flag set on AA-AA-03 header.
`timescale 1ns/1ps
module wk_key_builder
  import wk_pkg::*;
(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  frm_valid,
  input  wire logic [WIN_BYTES*8-1:0] frm_bytes,
  input  wire logic                  frm_is_eth,
  input  wire logic [1:0]            frm_vlan_cnt,
  input  wire logic [5:0]            frm_ptr,
  input  wire logic [15:0]           frm_sport,
  input  wire logic [15:0]           frm_dport,
  input  wire logic [11:0]           frm_vid,
  input  wire logic [5:0]            frm_dscp_remap,
  input  wire logic [15:0]           frm_custom,
  output logic                       key_valid,
  output logic [SA_BITS-1:0]         source_addr_key_field,
  output logic                       ethertype_encoded_flag,
  output logic                       ip_or_snap_flag,
  output logic                       ipv4_frame_flag,
  output logic                       transport_port_flag,
  output logic                       stream_transport_flag,
  output logic [15:0]                source_port_key_field,
  output logic [NUM_RNG-1:0]         range_match_mask,
  output logic [RAW_BYTES*8-1:0]     raw_payload_key_field
);
  // Register file state
  logic [2:0]            rng_type_r [NUM_RNG];
  logic [2:0]            rng_type_nxt [NUM_RNG];
  logic [31:0]           rng_lim_r [NUM_RNG];
  logic [31:0]           rng_lim_nxt [NUM_RNG];
  logic [31:0]           ctrl_r;
  logic [31:0]           ctrl_nxt;
  logic [15:0]           key_cnt_r;
  logic [15:0]           key_cnt_nxt;
  logic [31:0]           prdata_r;
  logic [31:0]           prdata_nxt;
  logic                  pready_r;
  logic                  pready_nxt;
  logic                  pslverr_r;
  logic                  pslverr_nxt;

  // Key output state
  logic                  kv_r;
  logic                  kv_nxt;
  logic [SA_BITS-1:0]    sa_r;
  logic [SA_BITS-1:0]    sa_nxt;
  logic                  etf_r;
  logic                  etf_nxt;
  logic                  ips_r;
  logic                  ips_nxt;
  logic                  v4_r;
  logic                  v4_nxt;
  logic                  tpf_r;
  logic                  tpf_nxt;
  logic                  stf_r;
  logic                  stf_nxt;
  logic [15:0]           sp_r;
  logic [15:0]           sp_nxt;
  logic [NUM_RNG-1:0]    rm_r;
  logic [NUM_RNG-1:0]    rm_nxt;
  logic [RAW_BYTES*8-1:0] raw_r;
  logic [RAW_BYTES*8-1:0] raw_nxt;

  // Decode helpers
  logic [7:0]            hdr_ofs;
  logic [7:0]            raw_ofs;
  logic [HDR_BYTES*8-1:0] hdr;
  logic [15:0]           type_len;
  logic [191:0]          l3;
  logic                  is_etype;
  logic                  is_snap;
  logic                  is_v4;
  logic                  is_v6;
  logic                  is_oam;
  logic [7:0]            proto;
  logic                  is_tcp;
  logic                  is_udp;
  logic [2:0]            mel;
  logic [NUM_RNG-1:0]    rng_hit;
  logic                  apb_setup;
  logic                  apb_wr;
  logic [3:0]            widx;
  logic                  hit_cfg;
  logic                  hit_lim;

  // Type/length sits after the MACs and any VLAN tags
  always_comb
  begin
    hdr_ofs = TL_OFS_BASE + {4'h0, frm_vlan_cnt, 2'b00};
  end

  // Raw field start
  // skip Ethernet layer
  always_comb
  begin
    raw_ofs = {2'b00, frm_ptr};
    if (frm_is_eth)
    begin
      raw_ofs = L2_HDR_BASE + {4'h0, frm_vlan_cnt, 2'b00} + {2'b00, frm_ptr};
    end
  end

  wk_byte_select #(.IN_BYTES(WIN_BYTES), .OUT_BYTES(HDR_BYTES)) u_hdr_sel (
    .win (frm_bytes),
    .ofs (hdr_ofs),
    .sel (hdr)
  );

  wk_byte_select #(.IN_BYTES(WIN_BYTES), .OUT_BYTES(RAW_BYTES)) u_raw_sel (
    .win (frm_bytes),
    .ofs (raw_ofs),
    .sel (raw_nxt)
  );

  // Frame type decode; l3 byte k sits at bits [191-8k -: 8]
  always_comb
  begin
    type_len = hdr[HDR_BYTES*8-1 -: 16];
    l3       = hdr[191:0];
    is_etype = (type_len >= ETYPE_MIN);
    is_snap  = !is_etype && (l3[191:168] == SNAP_SIG);
    is_v4    = is_etype && (type_len == ETYPE_IPV4) && (l3[191:188] == IP_VER4);
    is_v6    = is_etype && (type_len == ETYPE_IPV6) && (l3[191:188] == IP_VER6);
    is_oam   = is_etype && (type_len == ETYPE_OAM);
    proto    = is_v4 ? l3[119:112] : l3[143:136];
    is_tcp   = (is_v4 || is_v6) && (proto == PROTO_TCP);
    is_udp   = (is_v4 || is_v6) && (proto == PROTO_UDP);
    mel      = l3[191:189];
  end

  // Range checkers, one per mask bit
  for (genvar g = 0; g < NUM_RNG; g++)
  begin : g_rng
    wk_range_chk u_chk (
      .rng_type (rng_type_r[g]),
      .lo       (rng_lim_r[g][15:0]),
      .hi       (rng_lim_r[g][31:16]),
      .sport    (frm_sport),
      .dport    (frm_dport),
      .vid      (frm_vid),
      .dscp     (frm_dscp_remap),
      .custom   (frm_custom),
      .hit      (rng_hit[g])
    );
  end

  // Key field next values; held between frames
  always_comb
  begin
    kv_nxt  = frm_valid && ctrl_r[CTRL_EN_BIT];
    sa_nxt  = sa_r;
    etf_nxt = etf_r;
    ips_nxt = ips_r;
    v4_nxt  = v4_r;
    tpf_nxt = tpf_r;
    stf_nxt = stf_r;
    sp_nxt  = sp_r;
    rm_nxt  = rm_r;
    if (kv_nxt)
    begin
      etf_nxt = is_etype;
      ips_nxt = is_etype ? (is_v4 || is_v6) : is_snap;
      v4_nxt  = is_v4;
      if (!is_etype && !is_snap)
      begin
        sa_nxt = l3[175:48];
      end
      else if (!is_etype)
      begin
        sa_nxt = l3[151:24];
      end
      else if (is_v4)
      begin
        sa_nxt = {96'h0, l3[95:64]};
      end
      else if (is_v6)
      begin
        sa_nxt = l3[127:0];
      end
      else
      begin
        sa_nxt = l3[191:64];
      end
      tpf_nxt = is_tcp || is_udp || is_oam;
      stf_nxt = is_tcp;
      sp_nxt  = 16'h0000;
      if (is_oam)
      begin
        sp_nxt = 16'((17'h00001 << mel) - 17'h00001);
      end
      else if (is_tcp || is_udp)
      begin
        sp_nxt = frm_sport;
      end
      rm_nxt = rng_hit;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      kv_r  <= 1'b0;
      sa_r  <= '0;
      etf_r <= 1'b0;
      ips_r <= 1'b0;
      v4_r  <= 1'b0;
      tpf_r <= 1'b0;
      stf_r <= 1'b0;
      sp_r  <= 16'h0000;
      rm_r  <= '0;
      raw_r <= '0;
    end
    else
    begin
      kv_r  <= kv_nxt;
      sa_r  <= sa_nxt;
      etf_r <= etf_nxt;
      ips_r <= ips_nxt;
      v4_r  <= v4_nxt;
      tpf_r <= tpf_nxt;
      stf_r <= stf_nxt;
      sp_r  <= sp_nxt;
      rm_r  <= rm_nxt;
      // Raw field only moves with a new key
      if (kv_nxt)
      begin
        raw_r <= raw_nxt;
      end
    end
  end

  // APB slave: one setup cycle, answer in the first access cycle
  always_comb
  begin
    apb_setup = psel && !penable;
    apb_wr    = psel && penable && pready_r && pwrite && !pslverr_r;
    widx      = paddr[5:2] & 4'h7;
    hit_cfg   = (paddr[11:5] == RNG_CFG_BASE[11:5]) && (paddr[1:0] == 2'b00);
    hit_lim   = (paddr[11:5] == RNG_LIM_BASE[11:5]) && (paddr[1:0] == 2'b00);
    pready_nxt  = apb_setup;
    pslverr_nxt = apb_setup && !(hit_cfg || hit_lim || paddr == CTRL_OFS || paddr == STAT_OFS);
    prdata_nxt  = 32'h0000_0000;
    if (apb_setup && !pwrite)
    begin
      if (hit_cfg)
      begin
        prdata_nxt = {29'h0, rng_type_r[widx[2:0]]};
      end
      else if (hit_lim)
      begin
        prdata_nxt = rng_lim_r[widx[2:0]];
      end
      else if (paddr == CTRL_OFS)
      begin
        prdata_nxt = ctrl_r;
      end
      else if (paddr == STAT_OFS)
      begin
        prdata_nxt = {key_cnt_r, 8'h00, 3'b000, etf_r, ips_r, v4_r, tpf_r, stf_r};
      end
    end
    ctrl_nxt = ctrl_r;
    for (int i = 0; i < NUM_RNG; i++)
    begin
      rng_type_nxt[i] = rng_type_r[i];
      rng_lim_nxt[i]  = rng_lim_r[i];
    end
    if (apb_wr)
    begin
      if (hit_cfg)
      begin
        rng_type_nxt[widx[2:0]] = pwdata[2:0];
      end
      else if (hit_lim)
      begin
        rng_lim_nxt[widx[2:0]] = pwdata;
      end
      else if (paddr == CTRL_OFS)
      begin
        ctrl_nxt = {31'h0, pwdata[CTRL_EN_BIT]};
      end
    end
    // Counter wraps; software takes deltas
    key_cnt_nxt = kv_nxt ? key_cnt_r + 16'h0001 : key_cnt_r;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r    <= CTRL_RST;
      key_cnt_r <= 16'h0000;
      prdata_r  <= 32'h0000_0000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      for (int i = 0; i < NUM_RNG; i++)
      begin
        rng_type_r[i] <= 3'(WK_RNG_OFF);
        rng_lim_r[i]  <= LIM_RST;
      end
    end
    else
    begin
      ctrl_r    <= ctrl_nxt;
      key_cnt_r <= key_cnt_nxt;
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      for (int i = 0; i < NUM_RNG; i++)
      begin
        rng_type_r[i] <= rng_type_nxt[i];
        rng_lim_r[i]  <= rng_lim_nxt[i];
      end
    end
  end

  always_comb
  begin
    prdata                 = prdata_r;
    pready                 = pready_r;
    pslverr                = pslverr_r;
    key_valid              = kv_r;
    source_addr_key_field  = sa_r;
    ethertype_encoded_flag = etf_r;
    ip_or_snap_flag        = ips_r;
    ipv4_frame_flag        = v4_r;
    transport_port_flag    = tpf_r;
    stream_transport_flag  = stf_r;
    source_port_key_field  = sp_r;
    range_match_mask       = rm_r;
    raw_payload_key_field  = raw_r;
  end
endmodule

// ---- src/wk_pkg.sv ----
package wk_pkg;
  // Frame window seen by the builder, byte 0 in the top bits
  localparam int unsigned WIN_BYTES     = 160;
  localparam int unsigned HDR_BYTES     = 26;
  localparam int unsigned RAW_BYTES     = 64;
  localparam int unsigned SA_BITS       = 128;
  localparam int unsigned NUM_RNG       = 8;

  // Ethernet layer geometry
  localparam logic [7:0]  TL_OFS_BASE   = 8'h0c;
  localparam logic [7:0]  L2_HDR_BASE   = 8'h0e;
  localparam logic [7:0]  VLAN_TAG_LEN  = 8'h04;

  // Frame classification constants
  localparam logic [15:0] ETYPE_MIN     = 16'h0600;
  localparam logic [15:0] ETYPE_IPV4    = 16'h0800;
  localparam logic [15:0] ETYPE_IPV6    = 16'h86dd;
  localparam logic [15:0] ETYPE_OAM     = 16'h8902;
  localparam logic [23:0] SNAP_SIG      = 24'haaaa03;
  localparam logic [3:0]  IP_VER4       = 4'h4;
  localparam logic [3:0]  IP_VER6       = 4'h6;
  localparam logic [7:0]  PROTO_TCP     = 8'h06;
  localparam logic [7:0]  PROTO_UDP     = 8'h11;

  // Range checker type codes
  typedef enum logic [2:0] {
    WK_RNG_OFF, WK_RNG_SPORT, WK_RNG_DPORT, WK_RNG_EITHER,
    WK_RNG_VID, WK_RNG_DSCP, WK_RNG_CUSTOM
  } wk_rng_type_t;

  // APB register map (byte addresses)
  localparam logic [11:0] RNG_CFG_BASE  = 12'h000;
  localparam logic [11:0] RNG_LIM_BASE  = 12'h020;
  localparam logic [11:0] CTRL_OFS      = 12'h040;
  localparam logic [11:0] STAT_OFS      = 12'h044;
  localparam logic [31:0] CTRL_RST      = 32'h0000_0001;
  localparam logic [31:0] LIM_RST       = 32'hffff_0000;
  localparam int unsigned CTRL_EN_BIT   = 0;
endpackage

// ---- src/wk_range_chk.sv ----
`timescale 1ns/1ps
module wk_range_chk
  import wk_pkg::*;
(
  input  wire logic [2:0]  rng_type,
  input  wire logic [15:0] lo,
  input  wire logic [15:0] hi,
  input  wire logic [15:0] sport,
  input  wire logic [15:0] dport,
  input  wire logic [11:0] vid,
  input  wire logic [5:0]  dscp,
  input  wire logic [15:0] custom,
  output logic             hit
);
  function automatic logic in_rng(input logic [15:0] v, input logic [15:0] l, input logic [15:0] h);
    in_rng = (v >= l) && (v <= h);
  endfunction

  always_comb
  begin
    unique case (rng_type)
      WK_RNG_SPORT:  hit = in_rng(sport, lo, hi);
      WK_RNG_DPORT:  hit = in_rng(dport, lo, hi);
      WK_RNG_EITHER: hit = in_rng(sport, lo, hi) || in_rng(dport, lo, hi);
      WK_RNG_VID:    hit = in_rng({4'h0, vid}, lo, hi);
      WK_RNG_DSCP:   hit = in_rng({10'h000, dscp}, lo, hi);
      WK_RNG_CUSTOM: hit = in_rng(custom, lo, hi);
      // Spare codes never match
      default:       hit = 1'b0;
    endcase
  end
endmodule

// ---- verif/wk_frame_src.sv ----
`timescale 1ns/1ps
module wk_frame_src
  import wk_pkg::*;
(
  input  wire logic             pclk,
  output logic                  frm_valid,
  output logic [WIN_BYTES*8-1:0] frm_bytes,
  output logic                  frm_is_eth,
  output logic [1:0]            frm_vlan_cnt,
  output logic [5:0]            frm_ptr,
  output logic [15:0]           frm_sport,
  output logic [15:0]           frm_dport,
  output logic [11:0]           frm_vid,
  output logic [5:0]            frm_dscp_remap,
  output logic [15:0]           frm_custom
);
  logic [7:0] fb [WIN_BYTES];
  int         seed = 16;
  initial
  begin
    {frm_valid, frm_bytes, frm_is_eth, frm_vlan_cnt, frm_ptr} = '0;
    {frm_sport, frm_dport, frm_vid, frm_dscp_remap, frm_custom} = '0;
  end
  // Kinds: 0 llc, 1 snap, 2 ipv4, 3 ipv6, 4 other, 5 oam
  task automatic send(input int kind, input logic [7:0] arg);
    int                     l3;
    int                     len;
    logic [1:0]             vc;
    logic [WIN_BYTES*8-1:0] pk;
    @(posedge pclk);
    vc = 2'($random(seed));
    l3 = 14 + 4 * vc;
    len = 100 + int'(8'($random(seed)) % 60);
    // Bytes past the frame end read as zero
    for (int i = 0; i < WIN_BYTES; i++)
      fb[i] = (i < len) ? 8'($random(seed)) : 8'h00;
    case (kind)
      0: {fb[l3-2], fb[l3-1], fb[l3]} = {16'h0040, 8'hf0};
      1: {fb[l3-2], fb[l3-1], fb[l3], fb[l3+1], fb[l3+2]} = {16'h0040, SNAP_SIG};
      2: {fb[l3-2], fb[l3-1], fb[l3], fb[l3+9]} = {ETYPE_IPV4, 8'h45, arg};
      3: {fb[l3-2], fb[l3-1], fb[l3], fb[l3+6]} = {ETYPE_IPV6, 8'h60, arg};
      4: {fb[l3-2], fb[l3-1]} = 16'h1234;
      default: {fb[l3-2], fb[l3-1], fb[l3]} = {ETYPE_OAM, arg[2:0], 5'h00};
    endcase
    for (int i = 0; i < WIN_BYTES; i++)
      pk[(WIN_BYTES-1-i)*8 +: 8] = fb[i];
    frm_valid <= 1'b1;
    frm_bytes <= pk;
    frm_vlan_cnt <= vc;
    frm_is_eth <= 1'($random(seed));
    frm_ptr <= 6'($random(seed));
    // Small values so that range limits hit and miss
    frm_sport <= 16'($random(seed) & 63);
    frm_dport <= 16'($random(seed) & 63);
    frm_vid <= 12'($random(seed) & 63);
    frm_dscp_remap <= 6'($random(seed));
    frm_custom <= 16'($random(seed) & 63);
    @(posedge pclk);
    frm_valid <= 1'b0;
  endtask
endmodule

// ---- verif/wk_key_builder_sva.sv ----
`timescale 1ns/1ps
module wk_key_builder_sva
  import wk_pkg::*;
(
  input wire logic               pclk,
  input wire logic               presetn,
  input wire logic               frm_valid,
  input wire logic               key_valid,
  input wire logic [SA_BITS-1:0] source_addr_key_field,
  input wire logic               ethertype_encoded_flag,
  input wire logic               ip_or_snap_flag,
  input wire logic               ipv4_frame_flag,
  input wire logic               transport_port_flag,
  input wire logic               stream_transport_flag,
  input wire logic [15:0]        source_port_key_field,
  input wire logic [NUM_RNG-1:0] range_match_mask
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  key_lat_a: assert property (key_valid |-> $past(frm_valid))
    else $error("key without frame");
  key_hold_a: assert property (!key_valid |-> $stable(source_addr_key_field) && $stable(range_match_mask))
    else $error("key changed between frames");
  tcp_flag_a: assert property (stream_transport_flag |-> transport_port_flag && ip_or_snap_flag)
    else $error("stream flag on non ip frame");
  tp_etype_a: assert property (transport_port_flag |-> ethertype_encoded_flag)
    else $error("transport flag on length frame");
  ipv4_sa_a: assert property (ipv4_frame_flag |-> ip_or_snap_flag && source_addr_key_field[127:32] == '0)
    else $error("ipv4 source field upper bits");
  mel_code_a: assert property (transport_port_flag && !ip_or_snap_flag |-> source_port_key_field <= 16'h007f
    && (source_port_key_field & (source_port_key_field + 16'h0001)) == 16'h0000)
    else $error("level code not thermometer");
  l4_zero_a: assert property (!transport_port_flag |-> source_port_key_field == 16'h0000 && !stream_transport_flag)
    else $error("port field not zero");
  snap_flag_a: assert property (ip_or_snap_flag && !ethertype_encoded_flag |-> !ipv4_frame_flag)
    else $error("snap frame marked ipv4");
endmodule

bind wk_key_builder wk_key_builder_sva u_sva (.pclk, .presetn, .frm_valid, .key_valid, .source_addr_key_field,
  .ethertype_encoded_flag, .ip_or_snap_flag, .ipv4_frame_flag, .transport_port_flag, .stream_transport_flag,
  .source_port_key_field, .range_match_mask);

// ---- verif/wk_key_builder_tb.sv ----
`timescale 1ns/1ps
module wk_key_builder_tb
  import wk_pkg::*;
;
  logic                   pclk;
  logic                   presetn;
  logic                   psel;
  logic                   penable;
  logic                   pwrite;
  logic [11:0]            paddr;
  logic [31:0]            pwdata;
  logic [31:0]            prdata;
  logic                   pready;
  logic                   pslverr;
  logic                   frm_valid;
  logic [WIN_BYTES*8-1:0] frm_bytes;
  logic                   frm_is_eth;
  logic [1:0]             frm_vlan_cnt;
  logic [5:0]             frm_ptr;
  logic [15:0]            frm_sport;
  logic [15:0]            frm_dport;
  logic [11:0]            frm_vid;
  logic [5:0]             frm_dscp_remap;
  logic [15:0]            frm_custom;
  logic                   key_valid;
  logic [SA_BITS-1:0]     source_addr_key_field;
  logic                   ethertype_encoded_flag;
  logic                   ip_or_snap_flag;
  logic                   ipv4_frame_flag;
  logic                   transport_port_flag;
  logic                   stream_transport_flag;
  logic [15:0]            source_port_key_field;
  logic [NUM_RNG-1:0]     range_match_mask;
  logic [RAW_BYTES*8-1:0] raw_payload_key_field;
  logic [668:0]           q [$];
  logic [668:0]           e;
  logic [31:0]            rd;
  logic                   er;
  int                     failures = 0;
  int                     n_tests = 0;

  wk_key_builder u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .frm_valid, .frm_bytes, .frm_is_eth, .frm_vlan_cnt, .frm_ptr, .frm_sport, .frm_dport, .frm_vid,
    .frm_dscp_remap, .frm_custom, .key_valid, .source_addr_key_field, .ethertype_encoded_flag, .ip_or_snap_flag,
    .ipv4_frame_flag, .transport_port_flag, .stream_transport_flag, .source_port_key_field, .range_match_mask,
    .raw_payload_key_field);
  wk_frame_src u_src (.pclk, .frm_valid, .frm_bytes, .frm_is_eth, .frm_vlan_cnt, .frm_ptr, .frm_sport,
    .frm_dport, .frm_vid, .frm_dscp_remap, .frm_custom);

  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic chk(input string nm, input logic [511:0] s, input logic [511:0] x);
    n_tests++;
    if (s !== x)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, x, s);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Request held until the edge where pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // No wait count assumed; only the watchdog ends a hung access
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [7:0] b(input int i);
    return (i < WIN_BYTES) ? u_src.fb[i] : 8'h00;
  endfunction

  function automatic logic inr(input logic [15:0] v);
    return v >= 16'h0010 && v <= 16'h0020;
  endfunction

  task automatic exp_key(input int kind, input logic [7:0] arg);
    int           l3;
    int           bs;
    logic [127:0] sa;
    logic [511:0] raw;
    logic [15:0]  sp;
    logic [7:0]   m;
    logic         ip;
    logic         tp;
    l3 = 14 + 4 * frm_vlan_cnt;
    bs = (kind == 0) ? l3 + 2 : (kind == 1) ? l3 + 5 : (kind == 3) ? l3 + 8 : l3;
    for (int j = 0; j < 16; j++)
      sa[(15-j)*8 +: 8] = b(bs + j);
    if (kind == 2)
      sa = {96'h0, b(l3 + 12), b(l3 + 13), b(l3 + 14), b(l3 + 15)};
    ip = (kind == 2) || (kind == 3);
    tp = (ip && (arg == PROTO_TCP || arg == PROTO_UDP)) || (kind == 5);
    // level code, ones from bit zero
    sp = (kind == 5) ? 16'((1 << arg[2:0]) - 1) : (tp ? frm_sport : 16'h0000);
    m = {2'b00, inr(frm_custom), inr(16'(frm_dscp_remap)), inr(16'(frm_vid)), inr(frm_sport) | inr(frm_dport),
      inr(frm_dport), inr(frm_sport)};
    // raw field skips the Ethernet layer
    bs = (frm_is_eth ? l3 : 0) + frm_ptr;
    for (int j = 0; j < 64; j++)
      raw[(63-j)*8 +: 8] = b(bs + j);
    q.push_back({sa, kind > 1, kind > 0 && kind < 4, kind == 2, tp, ip && arg == PROTO_TCP, sp, m, raw});
  endtask

  // An unexpected key meets an unknown note and fails
  always @(negedge pclk)
  begin
    if (key_valid === 1'b1)
    begin
      e = (q.size() > 0) ? q.pop_front() : 'x;
      chk("source", source_addr_key_field, e[668:541]);
      chk("flags", {ethertype_encoded_flag, ip_or_snap_flag, ipv4_frame_flag, transport_port_flag,
        stream_transport_flag}, e[540:536]);
      chk("sport", source_port_key_field, e[535:520]);
      chk("range", range_match_mask, e[519:512]);
      chk("raw", raw_payload_key_field, e[511:0]);
      // Level at or above 3: bits 6..3 masked as don't care
      if (e[540:536] === 5'b10010)
        chk("level_rule", (source_port_key_field & 16'hff87) == 16'h0007, e[535:520] >= 16'h0007);
    end
  end

  initial
  begin
    repeat (5000) @(posedge pclk);
    failures++;
    test_done();
  end

  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, CTRL_OFS, 32'h0);
    chk("ctrl", rd, CTRL_RST);
    apb(1'b0, RNG_LIM_BASE, 32'h0);
    chk("limit", rd, LIM_RST);
    apb(1'b0, 12'h100, 32'h0);
    chk("unmapped", er, 1'b1);
    // every checker type, 7 never matches
    for (int i = 0; i < 8; i++)
    begin
      apb(1'b1, RNG_CFG_BASE + 12'(4 * i), 32'((i < 6) ? i + 1 : 7 * (i - 6)));
      apb(1'b1, RNG_LIM_BASE + 12'(4 * i), 32'h0020_0010);
    end
    // all eight levels sent, so mask rules can tell them apart
    for (int k = 0; k < 48; k++)
    begin
      u_src.send(k % 6, (k % 6 == 5) ? 8'(k / 6) : (k / 6 % 3 == 0) ? PROTO_TCP : (k / 6 % 3 == 1) ? PROTO_UDP : 8'h01);
      exp_key(k % 6, (k % 6 == 5) ? 8'(k / 6) : (k / 6 % 3 == 0) ? PROTO_TCP : (k / 6 % 3 == 1) ? PROTO_UDP : 8'h01);
    end
    // Disabled keys: frame must give no key
    apb(1'b1, CTRL_OFS, 32'h0);
    u_src.send(4, 8'h00);
    apb(1'b0, STAT_OFS, 32'h0);
    chk("count", rd[31:16], 16'd48);
    test_done();
  end
endmodule
